// ### gnp_pkg.sv
// Shared constants for the receiver serial port and time-mark link
// Notes on behaviour
// - Rates 4800 to 115200, both ends equal
// - Default 9600, eight data, no parity, one stop
// - Only data lines, no handshake, no clock
// - Device sends sentences, accepts commands
// - Default sentence set needs no configuration
// - Device transmit feeds host receive, and back
// - Serial zero routed to multiplexed pins
// - Pulse each second once 3D fix holds with at least four satellites in use
// - No fix keeps time mark low
// - Backup keeps memory and clock running
// - Backup supply unused unless enabled
// - Pulse high about 800 us, 1 Hz
package gnp_pkg;
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned MIN_SATS      = 4;
  localparam int unsigned PULSE_US      = 800;
  localparam int unsigned PULSE_CYC     = CLK_HZ / 1_000_000 * PULSE_US;
  localparam int unsigned SECOND_CYC    = CLK_HZ;
  localparam logic [2:0]  RATE_RESET    = 3'h1;
  localparam int unsigned DIV_W         = 16;
  localparam logic [3:0]  BIT_LAST      = 4'h9;

  typedef enum logic [2:0] {
    GNP_R4800   = 3'h0,
    GNP_R9600   = 3'h1,
    GNP_R14400  = 3'h2,
    GNP_R19200  = 3'h3,
    GNP_R38400  = 3'h4,
    GNP_R57600  = 3'h5,
    GNP_R115200 = 3'h6
  } gnp_rate_t;

  // Cycles per bit at each rate; unlisted codes fall back to the reset rate
  function automatic logic [DIV_W-1:0] bit_cycles(input logic [2:0] rate);
    logic [DIV_W-1:0] c;
    c = DIV_W'(CLK_HZ / 9600);
    unique case (rate)
      3'h0:    c = DIV_W'(CLK_HZ / 4800);
      3'h1:    c = DIV_W'(CLK_HZ / 9600);
      3'h2:    c = DIV_W'(CLK_HZ / 14400);
      3'h3:    c = DIV_W'(CLK_HZ / 19200);
      3'h4:    c = DIV_W'(CLK_HZ / 38400);
      3'h5:    c = DIV_W'(CLK_HZ / 57600);
      3'h6:    c = DIV_W'(CLK_HZ / 115200);
      default: c = DIV_W'(CLK_HZ / 9600);
    endcase
    return c;
  endfunction
endpackage

// ### gnp_link_if.sv
// Two-wire serial link plus time-mark line between receiver and host
`timescale 1ns/100ps
`default_nettype none
interface gnp_link_if;
  logic serial0_transmit_out;  // Device to host receive line
  logic serial0_receive_in;    // Host transmit line to device
  logic time_mark_pulse_out;   // Once-a-second mark
  // Device is communication_equipment_role, host is host_terminal_role
  modport communication_equipment_role (
    output serial0_transmit_out,
    input  serial0_receive_in,
    output time_mark_pulse_out
  );
  modport host_terminal_role (
    input  serial0_transmit_out,
    output serial0_receive_in,
    input  time_mark_pulse_out
  );
endinterface
`default_nettype wire

// ### gnp_device.sv
// Receiver end: serial port zero, time-mark generator, backup domain hold
`timescale 1ns/100ps
`default_nettype none
module gnp_device #(
  parameter int unsigned SECOND_CYC = gnp_pkg::SECOND_CYC,
  parameter int unsigned PULSE_CYC  = gnp_pkg::PULSE_CYC
) (
  input  wire logic       clk_in,             // 250 MHz clock
  input  wire logic       rst_n_in,           // Async reset, active low
  gnp_link_if.communication_equipment_role lnk, // Link to host
  input  wire logic [2:0] rate_sel_in,        // Rate code, applied on rate_load_in
  input  wire logic       rate_load_in,       // Pulse: take new rate
  input  wire logic [7:0] tx_data_in,         // Sentence byte to send
  input  wire logic       tx_valid_in,        // Byte offered
  output logic            tx_ready_out,       // Transmitter idle
  output logic [7:0]      rx_data_out,        // Command byte received
  output logic            rx_valid_out,       // Pulse: byte received
  output logic            rx_frame_err_out,   // Pulse: stop bit low
  input  wire logic       gpio_mode_in,       // High: pins used as general I/O
  input  wire logic       gpio_tx_level_in,   // Level driven in general I/O mode
  input  wire logic       fix_3d_in,          // Navigation has a 3D fix
  input  wire logic [5:0] sats_used_in,       // Satellites in solution
  input  wire logic       utc_second_in,      // Pulse: UTC second boundary
  input  wire logic       main_power_on_in,   // Main supply present
  input  wire logic       backup_enable_in,   // Firmware enables battery backup
  output logic [2:0]      rate_out,           // Active rate code
  output logic            sentences_all_out,  // Default sentence set active
  output logic            backup_hold_out,    // Memory and clock held on backup
  output logic [31:0]     rtc_seconds_out     // Seconds count kept through backup
);
  localparam int unsigned DW = gnp_pkg::DIV_W;

  // Rate register, reset to the power-up rate
  // Both bit counters read the rate live, so change it only between frames
  logic [2:0]    rate_ff;
  logic [DW-1:0] bit_len;
  logic [DW-1:0] half_len;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rate_ff <= gnp_pkg::RATE_RESET;
    end else if (rate_load_in && rate_sel_in <= 3'h6) begin
      rate_ff <= rate_sel_in;
    end
  end
  assign bit_len  = gnp_pkg::bit_cycles(rate_ff);
  assign half_len = bit_len >> 1;
  assign rate_out = rate_ff;
  // Filtering is left to firmware, so all default sentences always pass
  assign sentences_all_out = 1'b1;

  // Transmitter: ten-slot frame shifted out LSB first
  logic [9:0]    tx_sh_ff;
  logic [3:0]    tx_bit_ff;
  logic [DW-1:0] tx_cnt_ff;
  logic          tx_busy_ff;
  logic          tx_line;
  wire           tx_tick = (tx_cnt_ff == bit_len - DW'(1));
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh_ff   <= 10'h3FF;
      tx_bit_ff  <= 4'h0;
      tx_cnt_ff  <= '0;
      tx_busy_ff <= 1'b0;
    end else if (!tx_busy_ff) begin
      tx_cnt_ff <= '0;
      if (tx_valid_in) begin
        tx_sh_ff   <= {1'b1, tx_data_in, 1'b0};
        tx_bit_ff  <= 4'h0;
        tx_busy_ff <= 1'b1;
      end
    end else if (tx_tick) begin
      tx_cnt_ff <= '0;
      tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
      tx_bit_ff <= tx_bit_ff + 4'h1;
      if (tx_bit_ff == gnp_pkg::BIT_LAST) begin
        tx_busy_ff <= 1'b0;
      end
    end else begin
      tx_cnt_ff <= tx_cnt_ff + DW'(1);
    end
  end
  assign tx_ready_out = !tx_busy_ff;
  assign tx_line      = tx_sh_ff[0];  // Idle high
  // Pin mux: serial zero unless general I/O mode chosen; data lines only, no handshake
  wire           nxt_pin = gpio_mode_in ? gpio_tx_level_in : tx_line;
  // Registered pin, so a mode switch cannot glitch the host line; costs one cycle of latency
  logic          pin_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_ff <= 1'b1;  // Idle high out of reset
    end else begin
      pin_ff <= nxt_pin;
    end
  end
  assign lnk.serial0_transmit_out = pin_ff;

  // Receiver: mid-bit sampling, timer restarted by each start edge
  logic          rx_prev_ff;
  logic          rx_busy_ff;
  logic [3:0]    rx_bit_ff;
  logic [DW-1:0] rx_cnt_ff;
  logic [7:0]    rx_sh_ff;
  logic [7:0]    rx_data_ff;
  logic          rx_valid_ff;
  logic          rx_err_ff;
  wire           rx_pin   = gpio_mode_in ? 1'b1 : lnk.serial0_receive_in;
  wire           rx_fall  = rx_prev_ff && !rx_pin;
  wire           rx_mid   = (rx_bit_ff == 4'h0) ? (rx_cnt_ff == half_len) : (rx_cnt_ff == bit_len - DW'(1));
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_prev_ff  <= 1'b1;
      rx_busy_ff  <= 1'b0;
      rx_bit_ff   <= 4'h0;
      rx_cnt_ff   <= '0;
      rx_sh_ff    <= 8'h00;
      rx_data_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
      rx_err_ff   <= 1'b0;
    end else begin
      rx_prev_ff  <= rx_pin;
      rx_valid_ff <= 1'b0;
      rx_err_ff   <= 1'b0;
      if (!rx_busy_ff) begin
        rx_cnt_ff <= '0;
        rx_bit_ff <= 4'h0;
        if (rx_fall) begin
          rx_busy_ff <= 1'b1;
        end
      end else if (rx_mid) begin
        rx_cnt_ff <= '0;
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h0) begin
          // Glitch shorter than half a bit is not a start
          rx_busy_ff <= !rx_pin;
        end else if (rx_bit_ff == gnp_pkg::BIT_LAST) begin
          // A low stop bit drops the byte and raises only the error pulse
          rx_busy_ff  <= 1'b0;
          rx_valid_ff <= rx_pin;
          rx_err_ff   <= !rx_pin;
          if (rx_pin) begin
            rx_data_ff <= rx_sh_ff;
          end
        end else begin
          rx_sh_ff <= {rx_pin, rx_sh_ff[7:1]};
        end
      end else begin
        rx_cnt_ff <= rx_cnt_ff + DW'(1);
      end
    end
  end
  assign rx_data_out      = rx_data_ff;
  assign rx_valid_out     = rx_valid_ff;
  assign rx_frame_err_out = rx_err_ff;

  // Time mark: rises on the UTC second, held high for the pulse width
  logic        pps_ff;
  logic [31:0] pps_cnt_ff;
  wire         fix_ok = fix_3d_in && (sats_used_in >= 6'(gnp_pkg::MIN_SATS));
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pps_ff     <= 1'b0;
      pps_cnt_ff <= 32'h0;
    end else if (!fix_ok) begin
      pps_ff     <= 1'b0;
      pps_cnt_ff <= 32'h0;
    // A new second inside a pulse restarts the width count
    end else if (utc_second_in) begin
      pps_ff     <= 1'b1;
      pps_cnt_ff <= 32'h1;
    end else if (pps_ff) begin
      pps_cnt_ff <= pps_cnt_ff + 32'h1;
      if (pps_cnt_ff >= 32'(PULSE_CYC)) begin
        pps_ff <= 1'b0;
      end
    end
  end
  assign lnk.time_mark_pulse_out = pps_ff;

  // Backup domain: seconds clock counts while main power is on or backup is enabled
  logic [31:0] rtc_ff;
  logic [31:0] sub_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rtc_ff <= 32'h0;
      sub_ff <= 32'h0;
    end else if (main_power_on_in || backup_enable_in) begin
      // Without firmware enable the battery input is ignored
      if (sub_ff >= 32'(SECOND_CYC - 1)) begin
        sub_ff <= 32'h0;
        rtc_ff <= rtc_ff + 32'h1;
      end else begin
        sub_ff <= sub_ff + 32'h1;
      end
    end
  end
  // Hold flag registered like the other status outputs except the constant sentences_all_out; follows the supplies one cycle late
  wire           nxt_hold = !main_power_on_in && backup_enable_in;
  logic          hold_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
    end
  end
  assign backup_hold_out = hold_ff;
  assign rtc_seconds_out = rtc_ff;
endmodule
`default_nettype wire

// ### gnp_host.sv
// Host terminal end: serial port toward the receiver and time-mark edge capture
`timescale 1ns/100ps
`default_nettype none
module gnp_host (
  input  wire logic       clk_in,          // 250 MHz clock
  input  wire logic       rst_n_in,        // Async reset, active low
  gnp_link_if.host_terminal_role lnk,      // Link to receiver
  input  wire logic [2:0] rate_sel_in,     // Rate code, must match device
  input  wire logic       rate_load_in,    // Pulse: take new rate
  input  wire logic [7:0] cmd_data_in,     // Command byte to send
  input  wire logic       cmd_valid_in,    // Byte offered
  output logic            cmd_ready_out,   // Transmitter idle
  output logic [7:0]      nmea_data_out,   // Sentence byte received
  output logic            nmea_valid_out,  // Pulse: byte received
  output logic            nmea_err_out,    // Pulse: stop bit low
  output logic            second_out       // Pulse: time mark rising edge
);
  localparam int unsigned DW = gnp_pkg::DIV_W;

  // Rate register mirrors the device power-up rate
  logic [2:0]    rate_ff;
  logic [DW-1:0] bit_len;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rate_ff <= gnp_pkg::RATE_RESET;
    end else if (rate_load_in && rate_sel_in <= 3'h6) begin
      rate_ff <= rate_sel_in;
    end
  end
  assign bit_len = gnp_pkg::bit_cycles(rate_ff);

  // Transmitter drives device receive line, no handshake lines exist
  logic [9:0]    tx_sh_ff;
  logic [3:0]    tx_bit_ff;
  logic [DW-1:0] tx_cnt_ff;
  logic          tx_busy_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_sh_ff   <= 10'h3FF;
      tx_bit_ff  <= 4'h0;
      tx_cnt_ff  <= '0;
      tx_busy_ff <= 1'b0;
    end else if (!tx_busy_ff) begin
      tx_cnt_ff <= '0;
      if (cmd_valid_in) begin
        tx_sh_ff   <= {1'b1, cmd_data_in, 1'b0};
        tx_bit_ff  <= 4'h0;
        tx_busy_ff <= 1'b1;
      end
    end else if (tx_cnt_ff == bit_len - DW'(1)) begin
      tx_cnt_ff <= '0;
      tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
      tx_bit_ff <= tx_bit_ff + 4'h1;
      if (tx_bit_ff == gnp_pkg::BIT_LAST) begin
        tx_busy_ff <= 1'b0;
      end
    end else begin
      tx_cnt_ff <= tx_cnt_ff + DW'(1);
    end
  end
  assign cmd_ready_out          = !tx_busy_ff;
  assign lnk.serial0_receive_in = tx_sh_ff[0];

  // Receiver on the device transmit line, mid-bit sampling
  logic          rx_prev_ff;
  logic          rx_busy_ff;
  logic [3:0]    rx_bit_ff;
  logic [DW-1:0] rx_cnt_ff;
  logic [7:0]    rx_sh_ff;
  logic [7:0]    rx_data_ff;
  logic          rx_valid_ff;
  logic          rx_err_ff;
  wire           rx_pin = lnk.serial0_transmit_out;
  wire           rx_mid = (rx_bit_ff == 4'h0) ? (rx_cnt_ff == (bit_len >> 1)) : (rx_cnt_ff == bit_len - DW'(1));
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_prev_ff  <= 1'b1;
      rx_busy_ff  <= 1'b0;
      rx_bit_ff   <= 4'h0;
      rx_cnt_ff   <= '0;
      rx_sh_ff    <= 8'h00;
      rx_data_ff  <= 8'h00;
      rx_valid_ff <= 1'b0;
      rx_err_ff   <= 1'b0;
    end else begin
      rx_prev_ff  <= rx_pin;
      rx_valid_ff <= 1'b0;
      rx_err_ff   <= 1'b0;
      if (!rx_busy_ff) begin
        rx_cnt_ff  <= '0;
        rx_bit_ff  <= 4'h0;
        rx_busy_ff <= rx_prev_ff && !rx_pin;
      end else if (rx_mid) begin
        rx_cnt_ff <= '0;
        rx_bit_ff <= rx_bit_ff + 4'h1;
        if (rx_bit_ff == 4'h0) begin
          rx_busy_ff <= !rx_pin;
        end else if (rx_bit_ff == gnp_pkg::BIT_LAST) begin
          rx_busy_ff  <= 1'b0;
          rx_valid_ff <= rx_pin;
          rx_err_ff   <= !rx_pin;
          if (rx_pin) begin
            rx_data_ff <= rx_sh_ff;
          end
        end else begin
          rx_sh_ff <= {rx_pin, rx_sh_ff[7:1]};
        end
      end else begin
        rx_cnt_ff <= rx_cnt_ff + DW'(1);
      end
    end
  end
  assign nmea_data_out  = rx_data_ff;
  assign nmea_valid_out = rx_valid_ff;
  assign nmea_err_out   = rx_err_ff;

  // Time-mark rising edge detect
  logic pps_prev_ff;
  logic sec_ff;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pps_prev_ff <= 1'b0;
      sec_ff      <= 1'b0;
    end else begin
      pps_prev_ff <= lnk.time_mark_pulse_out;
      sec_ff      <= lnk.time_mark_pulse_out && !pps_prev_ff;
    end
  end
  assign second_out = sec_ff;
endmodule
`default_nettype wire

// ### gnp_link_asserts.sv
// Checker on the serial link wires and the time mark
`timescale 1ns/100ps
`default_nettype none
module gnp_link_asserts #(
  parameter int unsigned PULSE_CYC = gnp_pkg::PULSE_CYC
) (
  input wire logic clk_in,               // Clock
  input wire logic rst_n_in,             // Async reset, active low
  input wire logic serial0_transmit_out, // Device to host line
  input wire logic serial0_receive_in,   // Host to device line
  input wire logic time_mark_pulse_out   // Time mark
);
  localparam int MIN_BIT = 2170;      // Shortest bit, fastest rate
  localparam int MAX_LOW = 9 * 52083; // Start and eight zeros, slowest rate
  logic [31:0] tx_lo_ff;
  logic [31:0] rx_lo_ff;
  logic [31:0] hi_ff;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Run lengths; a low run shorter than one bit means a glitch
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_lo_ff <= '0;
      rx_lo_ff <= '0;
      hi_ff    <= '0;
    end else begin
      tx_lo_ff <= serial0_transmit_out ? '0 : tx_lo_ff + 32'h1;
      rx_lo_ff <= serial0_receive_in ? '0 : rx_lo_ff + 32'h1;
      hi_ff    <= time_mark_pulse_out ? hi_ff + 32'h1 : '0;
    end
  end
  a_idle_after_reset: assert property ($rose(rst_n_in) |-> serial0_transmit_out && serial0_receive_in)
    else $error("link not idle high after reset");
  a_mark_low_reset: assert property ($rose(rst_n_in) |-> !time_mark_pulse_out)
    else $error("time mark high after reset");
  a_tx_start_hold: assert property ($fell(serial0_transmit_out) |-> !serial0_transmit_out [*8])
    else $error("device start bit too short");
  a_rx_start_hold: assert property ($fell(serial0_receive_in) |-> !serial0_receive_in [*8])
    else $error("host start bit too short");
  a_tx_bit_min: assert property ($rose(serial0_transmit_out) |-> tx_lo_ff >= MIN_BIT)
    else $error("device low run below one bit");
  a_rx_bit_min: assert property ($rose(serial0_receive_in) |-> rx_lo_ff >= MIN_BIT)
    else $error("host low run below one bit");
  a_tx_low_max: assert property (tx_lo_ff <= MAX_LOW)
    else $error("device line low beyond a frame");
  a_mark_width: assert property ($fell(time_mark_pulse_out) |-> hi_ff == PULSE_CYC)
    else $error("time mark width wrong");
  a_mark_max: assert property (hi_ff <= PULSE_CYC)
    else $error("time mark too long");
  c_mark: cover property ($fell(time_mark_pulse_out));
  c_tx_frame: cover property ($rose(serial0_transmit_out));
  c_rx_frame: cover property ($rose(serial0_receive_in));
endmodule
`default_nettype wire

// ### gnp_uart_and_pps_port_test.sv
// Testbench joining receiver and host ends over the link
`timescale 1ns/100ps
`default_nettype none
module gnp_uart_and_pps_port_test;
  localparam int unsigned PULSE = 50;
  localparam int NB = gnp_pkg::CLK_HZ / 115200;
  logic clk_in = 1'h0, rst_n_in = 1'h0, rate_load_in = 1'h0, tx_valid_in = 1'h0, cmd_valid_in = 1'h0;
  logic gpio_mode_in = 1'h0, gpio_tx_level_in = 1'h1, fix_3d_in = 1'h0, utc_second_in = 1'h0;
  logic main_power_on_in = 1'h1, backup_enable_in = 1'h0;
  logic [2:0] rate_sel_in = 3'h1;
  logic [7:0] tx_data_in = 8'h00, cmd_data_in = 8'h00;
  logic [5:0] sats_used_in = 6'h00;
  logic tx_ready_out, rx_valid_out, rx_frame_err_out, sentences_all_out, backup_hold_out;
  logic cmd_ready_out, nmea_valid_out, nmea_err_out, second_out;
  logic [2:0] rate_out;
  logic [7:0] rx_data_out, nmea_data_out;
  logic [31:0] rtc_seconds_out;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  logic [31:0] rtc0;
  bit saw_err;

  gnp_link_if i_gnp_link_if ();
  gnp_link_asserts #(.PULSE_CYC(PULSE)) i_gnp_link_asserts (.clk_in, .rst_n_in,
    .serial0_transmit_out(i_gnp_link_if.serial0_transmit_out),
    .serial0_receive_in(i_gnp_link_if.serial0_receive_in),
    .time_mark_pulse_out(i_gnp_link_if.time_mark_pulse_out));
  // Short second and pulse keep the run brief
  gnp_device #(.SECOND_CYC(1000), .PULSE_CYC(PULSE)) i_gnp_device (.clk_in, .rst_n_in, .lnk(i_gnp_link_if),
    .rate_sel_in, .rate_load_in, .tx_data_in, .tx_valid_in, .tx_ready_out, .rx_data_out, .rx_valid_out,
    .rx_frame_err_out, .gpio_mode_in, .gpio_tx_level_in, .fix_3d_in, .sats_used_in, .utc_second_in,
    .main_power_on_in, .backup_enable_in, .rate_out, .sentences_all_out, .backup_hold_out, .rtc_seconds_out);
  gnp_host i_gnp_host (.clk_in, .rst_n_in, .lnk(i_gnp_link_if), .rate_sel_in, .rate_load_in,
    .cmd_data_in, .cmd_valid_in, .cmd_ready_out, .nmea_data_out, .nmea_valid_out, .nmea_err_out, .second_out);

  always #2 clk_in = ~clk_in;
  // Hang guard, a little above the expected run
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 98000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Offer a byte once ready is seen, hold valid until the taking edge
  task automatic send(input bit dev, input logic [7:0] b);
    @(negedge clk_in);
    while ((dev ? tx_ready_out : cmd_ready_out) !== 1'h1) @(negedge clk_in);
    @(posedge clk_in);
    if (dev) begin
      tx_data_in <= b;
      tx_valid_in <= 1'h1;
      @(posedge clk_in);
      tx_valid_in <= 1'h0;
    end else begin
      cmd_data_in <= b;
      cmd_valid_in <= 1'h1;
      @(posedge clk_in);
      cmd_valid_in <= 1'h0;
    end
  endtask

  function automatic logic line(input bit dev);
    return dev ? i_gnp_link_if.serial0_transmit_out : i_gnp_link_if.serial0_receive_in;
  endfunction

  // Sample a frame mid-bit on the wire, then the byte at the far end
  task automatic watch(input bit dev, input logic [7:0] b);
    bit got;
    bit bad;
    got = 0;
    bad = 0;
    do @(negedge clk_in); while (line(dev) !== 1'h0);
    tick(NB / 2);
    check("start bit", line(dev), 1'h0);
    for (int i = 0; i < 8; i++) begin
      tick(NB);
      check("data bit", line(dev), b[i]);
    end
    for (int k = 0; k < NB + NB / 4; k++) begin
      @(negedge clk_in);
      if (k == NB - 1) check("stop bit", line(dev), 1'h1);
      if ((dev ? nmea_err_out : rx_frame_err_out) === 1'h1) bad = 1;
      if ((dev ? nmea_valid_out : rx_valid_out) === 1'h1) begin
        got = 1;
        check("byte", dev ? nmea_data_out : rx_data_out, b);
      end
    end
    check("byte seen", got, 1'h1);
    check("no frame error", bad, 1'h0);
  endtask

  // One UTC second with given fix state; count mark samples and host edge
  task automatic mark_try(input logic f, input logic [5:0] s, input int exp);
    int n, sec;
    n = 0;
    sec = -1;
    @(posedge clk_in);
    fix_3d_in <= f;
    sats_used_in <= s;
    @(posedge clk_in);
    utc_second_in <= 1'h1;
    @(posedge clk_in);
    utc_second_in <= 1'h0;
    for (int k = 0; k < 100; k++) begin
      @(negedge clk_in);
      if (i_gnp_link_if.time_mark_pulse_out === 1'h1) n++;
      if (second_out === 1'h1 && sec < 0) sec = k;
    end
    check("mark width", n, exp);
    check("host second", sec, exp > 0 ? 1 : -1);
  endtask

  initial begin
    tick(10);
    @(posedge clk_in);
    rst_n_in <= 1'h1;
    tick(1);
    check("rate", rate_out, 3'h1);
    check("sentences", sentences_all_out, 1'h1);
    check("rtc", rtc_seconds_out, 32'h0);
    check("idle", {line(1), line(0), i_gnp_link_if.time_mark_pulse_out}, 3'h6);
    // Start bit at the default rate, then reset in mid-frame
    fork
      send(1, 8'hFF);
      begin : len
        int n;
        n = 0;
        do @(negedge clk_in); while (line(1) !== 1'h0);
        while (line(1) === 1'h0 && n < 30000) begin
          n++;
          @(negedge clk_in);
        end
        check("start length", n, gnp_pkg::CLK_HZ / 9600);
      end
    join
    @(posedge clk_in);
    rst_n_in <= 1'h0;
    tick(10);
    @(posedge clk_in);
    rst_n_in <= 1'h1;
    tick(1);
    check("idle again", {line(1), tx_ready_out}, 2'h3);
    // Every rate code, then the unused code leaves the last one
    for (int r = 0; r < 8; r++) begin
      @(posedge clk_in);
      rate_sel_in <= r[2:0];
      rate_load_in <= 1'h1;
      @(posedge clk_in);
      rate_load_in <= 1'h0;
      @(negedge clk_in);
      check("rate", rate_out, r == 7 ? 3'h6 : r[2:0]);
    end
    // Both directions at once, device bytes back to back
    fork
      begin
        send(1, 8'hA5);
        send(1, 8'h3C);
      end
      begin
        watch(1, 8'hA5);
        watch(1, 8'h3C);
      end
      send(0, 8'h96);
      watch(0, 8'h96);
    join
    mark_try(1'h1, 6'h04, PULSE);
    mark_try(1'h1, 6'h03, 0);
    mark_try(1'h0, 6'h04, 0);
    // Backup hold follows main power and the enable; clock stops without the enable
    @(posedge clk_in);
    main_power_on_in <= 1'h0;
    tick(2);
    check("backup off", backup_hold_out, 1'h0);
    rtc0 = rtc_seconds_out;
    tick(1000);
    check("rtc frozen", rtc_seconds_out, rtc0);
    @(posedge clk_in);
    backup_enable_in <= 1'h1;
    tick(2);
    check("backup on", backup_hold_out, 1'h1);
    // Exactly one short second of counting edges since the enable
    tick(999);
    check("rtc on backup", rtc_seconds_out, rtc0 + 32'h1);
    @(posedge clk_in);
    main_power_on_in <= 1'h1;
    tick(2);
    check("main on", backup_hold_out, 1'h0);
    // General I/O mode holds the pin low past the host's stop-bit sample: host flags a bad stop bit
    @(posedge clk_in);
    gpio_mode_in <= 1'h1;
    gpio_tx_level_in <= 1'h0;
    saw_err = 0;
    repeat (21000) begin
      @(negedge clk_in);
      if (nmea_err_out === 1'h1) saw_err = 1;
    end
    check("gpio low", line(1), 1'h0);
    check("host frame error", saw_err, 1'h1);
    @(posedge clk_in);
    gpio_tx_level_in <= 1'h1;
    tick(20);
    check("gpio high", line(1), 1'h1);
    conclude();
  end
endmodule
`default_nettype wire
